// ---- hdl/reg_bits.sv ----
`timescale 1ns/1ps

// Overview of operation
// - Read-only fields return live value; writes change nothing.
// - Write-only field takes writes; read value is meaningless.
// - Write-one-to-set bits: one sets, zero leaves alone.
// - Write-one-to-clear bits: one clears, zero leaves alone.
// - Any write to write-any-to-clear field clears it.
// - Read-to-clear field returns contents then clears; writes ignored.
// - Latch-low bit holds low indication until register read.
// - Latch-high bit holds high indication until register read.
// - Self-clearing bit returns to zero alone; zero writes ignored.
// - Sticky-high bit stays one after condition until read.
// - After read, sticky bit follows whether condition still holds.
// - Unread sticky bit ignores condition changes, keeps reading one.
// - Soft-reset-immune bits keep their value through soft reset.
module reg_bits #(
    parameter int CNT_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire reg_bits_pkg::access_req_t req,
    output reg_bits_pkg::access_rsp_t rsp,
    input wire reg_bits_pkg::hw_in_t hw,
    output logic [reg_bits_pkg::CTRL_RW_W-1:0] ctrl_rw,
    output logic [reg_bits_pkg::CTRL_IMMUNE_W-1:0] ctrl_immune,
    output logic soft_reset,
    output logic [reg_bits_pkg::FLAG_W-1:0] cmd_pulse,
    output logic [reg_bits_pkg::FLAG_W-1:0] cmd_enable,
    output logic key_stb,
    output logic [reg_bits_pkg::DATA_W-1:0] key_data
);

    // ****************************************************
    // Parameter check
    // ****************************************************
    if (CNT_W < 1 || CNT_W > reg_bits_pkg::DATA_W) begin : g_bad_cnt_w
        $error("CNT_W must lie between 1 and DATA_W");
    end

    // ****************************************************
    // State
    // ****************************************************
    logic [reg_bits_pkg::FLAG_W-1:0] event_flags;
    logic [CNT_W-1:0] err_count;
    logic [CNT_W-1:0] hit_count;
    logic [reg_bits_pkg::FLAG_W-1:0] latch_high_clear_on_read;
    logic [reg_bits_pkg::FLAG_W-1:0] latch_low_clear_on_read;
    logic [reg_bits_pkg::FLAG_W-1:0] read_only_sticky_high;

    logic [reg_bits_pkg::CTRL_RW_W-1:0] next_ctrl_rw;
    logic [reg_bits_pkg::CTRL_IMMUNE_W-1:0] next_ctrl_immune;
    logic next_soft_reset;
    logic [reg_bits_pkg::FLAG_W-1:0] next_cmd_pulse;
    logic [reg_bits_pkg::FLAG_W-1:0] next_cmd_enable;
    logic [reg_bits_pkg::FLAG_W-1:0] next_event_flags;
    logic [CNT_W-1:0] next_err_count;
    logic [CNT_W-1:0] next_hit_count;
    logic [reg_bits_pkg::FLAG_W-1:0] next_latch_high;
    logic [reg_bits_pkg::FLAG_W-1:0] next_latch_low;
    logic [reg_bits_pkg::FLAG_W-1:0] next_sticky;
    logic next_key_stb;
    logic [reg_bits_pkg::DATA_W-1:0] next_key_data;
    reg_bits_pkg::access_rsp_t next_rsp;

    logic [reg_bits_pkg::DATA_W-1:0] wd;
    logic [reg_bits_pkg::FLAG_W-1:0] wd_pulse;
    logic [reg_bits_pkg::FLAG_W-1:0] wd_enable;
    logic [reg_bits_pkg::FLAG_W-1:0] wd_event;

    assign wd = req.wdata;
    assign wd_pulse = wd[reg_bits_pkg::CMD_PULSE_LSB +:
                         reg_bits_pkg::FLAG_W];
    assign wd_enable = wd[reg_bits_pkg::CMD_ENABLE_LSB +:
                          reg_bits_pkg::FLAG_W];
    assign wd_event = wd[reg_bits_pkg::FLAG_W-1:0];

    // ****************************************************
    // Next-state logic
    // ****************************************************
    // Hardware set wins over a clear in the same cycle, except a soft reset, which clears it.
    always_comb begin
        next_ctrl_rw = ctrl_rw;
        next_ctrl_immune = ctrl_immune;
        next_soft_reset = 1'b0;
        next_cmd_pulse = '0;
        next_cmd_enable = cmd_enable & ~hw.enable_clear;
        next_event_flags = event_flags;
        next_err_count = err_count;
        next_hit_count = hit_count;
        next_latch_high = latch_high_clear_on_read;
        next_latch_low = latch_low_clear_on_read;
        next_sticky = read_only_sticky_high;
        next_key_stb = 1'b0;
        next_key_data = key_data;
        next_rsp.valid = req.rd;
        next_rsp.data = '0;

        // Read data; reserved and write-only bits read as zero
        if (req.rd) begin
            if (req.addr == reg_bits_pkg::OFS_CTRL) begin
                next_rsp.data[reg_bits_pkg::CTRL_RW_LSB +:
                              reg_bits_pkg::CTRL_RW_W] = ctrl_rw;
                next_rsp.data[reg_bits_pkg::CTRL_IMMUNE_LSB +:
                              reg_bits_pkg::CTRL_IMMUNE_W] = ctrl_immune;
            end else if (req.addr == reg_bits_pkg::OFS_HW_STATUS) begin
                next_rsp.data = hw.status;
            end else if (req.addr == reg_bits_pkg::OFS_EVENT) begin
                next_rsp.data[reg_bits_pkg::FLAG_W-1:0] = event_flags;
            end else if (req.addr == reg_bits_pkg::OFS_COMMAND) begin
                next_rsp.data[reg_bits_pkg::CMD_PULSE_LSB +:
                              reg_bits_pkg::FLAG_W] = cmd_pulse;
                next_rsp.data[reg_bits_pkg::CMD_ENABLE_LSB +:
                              reg_bits_pkg::FLAG_W] = cmd_enable;
            end else if (req.addr == reg_bits_pkg::OFS_ERR_COUNT) begin
                next_rsp.data[CNT_W-1:0] = err_count;
            end else if (req.addr == reg_bits_pkg::OFS_HIT_COUNT) begin
                next_rsp.data[CNT_W-1:0] = hit_count;
            end else if (req.addr == reg_bits_pkg::OFS_LATCH) begin
                next_rsp.data[reg_bits_pkg::LATCH_HIGH_LSB +:
                              reg_bits_pkg::FLAG_W] = latch_high_clear_on_read;
                next_rsp.data[reg_bits_pkg::LATCH_LOW_LSB +:
                              reg_bits_pkg::FLAG_W] = latch_low_clear_on_read;
                next_rsp.data[reg_bits_pkg::STICKY_LSB +:
                              reg_bits_pkg::FLAG_W] = read_only_sticky_high;
            end else begin
                next_rsp.data = '0;
            end
        end

        // Writes; read-only and read-to-clear registers take none
        if (req.wr) begin
            if (req.addr == reg_bits_pkg::OFS_CTRL) begin
                next_ctrl_rw = wd[reg_bits_pkg::CTRL_RW_LSB +:
                                  reg_bits_pkg::CTRL_RW_W];
                next_ctrl_immune = wd[reg_bits_pkg::CTRL_IMMUNE_LSB +:
                                      reg_bits_pkg::CTRL_IMMUNE_W];
                next_soft_reset = wd[reg_bits_pkg::CTRL_SOFT_RST_BIT];
            end else if (req.addr == reg_bits_pkg::OFS_EVENT) begin
                next_event_flags = event_flags & ~wd_event;
            end else if (req.addr == reg_bits_pkg::OFS_COMMAND) begin
                next_cmd_pulse = wd_pulse;
                next_cmd_enable = next_cmd_enable | wd_enable;
            end else if (req.addr == reg_bits_pkg::OFS_ERR_COUNT) begin
                next_err_count = '0;
            end else if (req.addr == reg_bits_pkg::OFS_KEY) begin
                next_key_stb = 1'b1;
                next_key_data = wd;
            end
        end

        // Read side effects
        if (req.rd && req.addr == reg_bits_pkg::OFS_HIT_COUNT) begin
            next_hit_count = '0;
        end
        if (req.rd && req.addr == reg_bits_pkg::OFS_LATCH) begin
            next_latch_high = '0;
            next_latch_low = hw.low_cond;
            next_sticky = hw.sticky_cond;
        end else begin
            next_latch_low = latch_low_clear_on_read & hw.low_cond;
            next_sticky = read_only_sticky_high | hw.sticky_cond;
        end

        // Hardware sets, applied after the accesses so they win over them
        next_event_flags = next_event_flags | hw.event_pulse;
        next_latch_high = next_latch_high | hw.high_event;
        next_sticky = next_sticky | hw.sticky_cond;
        if (hw.err_pulse && next_err_count != {CNT_W{1'b1}}) begin
            next_err_count = next_err_count + 1'b1;
        end
        // Counters saturate rather than wrap, so a full count stays true
        if (hw.hit_pulse && next_hit_count != {CNT_W{1'b1}}) begin
            next_hit_count = next_hit_count + 1'b1;
        end

        // Soft reset spares only the immune field; events then are lost
        if (soft_reset) begin
            next_ctrl_rw = reg_bits_pkg::RST_CTRL_RW;
            next_ctrl_immune = ctrl_immune;
            next_soft_reset = 1'b0;
            next_cmd_pulse = reg_bits_pkg::RST_FLAGS;
            next_cmd_enable = reg_bits_pkg::RST_FLAGS;
            next_event_flags = reg_bits_pkg::RST_FLAGS;
            next_err_count = '0;
            next_hit_count = '0;
            next_latch_high = reg_bits_pkg::RST_FLAGS;
            next_latch_low = reg_bits_pkg::RST_LATCH_LOW;
            next_sticky = reg_bits_pkg::RST_FLAGS;
            next_key_stb = 1'b0;
            next_key_data = '0;
            next_rsp = '0;
        end
    end

    // ****************************************************
    // Registers
    // ****************************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_rw <= reg_bits_pkg::RST_CTRL_RW;
            ctrl_immune <= reg_bits_pkg::RST_CTRL_IMMUNE;
            soft_reset <= 1'b0;
            cmd_pulse <= reg_bits_pkg::RST_FLAGS;
            cmd_enable <= reg_bits_pkg::RST_FLAGS;
            event_flags <= reg_bits_pkg::RST_FLAGS;
            err_count <= '0;
            hit_count <= '0;
            latch_high_clear_on_read <= reg_bits_pkg::RST_FLAGS;
            latch_low_clear_on_read <= reg_bits_pkg::RST_LATCH_LOW;
            read_only_sticky_high <= reg_bits_pkg::RST_FLAGS;
            key_stb <= 1'b0;
            key_data <= '0;
            rsp <= '0;
        end else begin
            ctrl_rw <= next_ctrl_rw;
            ctrl_immune <= next_ctrl_immune;
            soft_reset <= next_soft_reset;
            cmd_pulse <= next_cmd_pulse;
            cmd_enable <= next_cmd_enable;
            event_flags <= next_event_flags;
            err_count <= next_err_count;
            hit_count <= next_hit_count;
            latch_high_clear_on_read <= next_latch_high;
            latch_low_clear_on_read <= next_latch_low;
            read_only_sticky_high <= next_sticky;
            key_stb <= next_key_stb;
            key_data <= next_key_data;
            rsp <= next_rsp;
        end
    end

endmodule

// ---- hdl/reg_bits_pkg.sv ----
package reg_bits_pkg;

    // ****************************************************
    // Widths
    // ****************************************************
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam int FLAG_W = 4;

    // ****************************************************
    // Register indices
    // ****************************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_HW_STATUS = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_EVENT = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_COMMAND = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_ERR_COUNT = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_HIT_COUNT = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_LATCH = 3'h6;
    localparam logic [ADDR_W-1:0] OFS_KEY = 3'h7;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int CTRL_RW_LSB = 0;
    localparam int CTRL_RW_W = 8;
    localparam int CTRL_IMMUNE_LSB = 8;
    localparam int CTRL_IMMUNE_W = 4;
    localparam int CTRL_SOFT_RST_BIT = 15;
    localparam int CMD_PULSE_LSB = 0;
    localparam int CMD_ENABLE_LSB = 4;
    localparam int LATCH_HIGH_LSB = 0;
    localparam int LATCH_LOW_LSB = 4;
    localparam int STICKY_LSB = 8;

    // ****************************************************
    // Values after reset
    // ****************************************************
    localparam logic [CTRL_RW_W-1:0] RST_CTRL_RW = 8'h00;
    localparam logic [CTRL_IMMUNE_W-1:0] RST_CTRL_IMMUNE = 4'h0;
    localparam logic [FLAG_W-1:0] RST_FLAGS = 4'h0;
    localparam logic [FLAG_W-1:0] RST_LATCH_LOW = 4'hF;

    // ****************************************************
    // Carriers
    // ****************************************************
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } access_req_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } access_rsp_t;

    typedef struct packed {
        logic [DATA_W-1:0] status;
        logic [FLAG_W-1:0] event_pulse;
        logic [FLAG_W-1:0] enable_clear;
        logic err_pulse;
        logic hit_pulse;
        logic [FLAG_W-1:0] high_event;
        logic [FLAG_W-1:0] low_cond;
        logic [FLAG_W-1:0] sticky_cond;
    } hw_in_t;

endpackage

// ---- dv/reg_bits_sva.sv ----
`timescale 1ns/1ps

// ********
// Checker on the top ports
// ********
module reg_bits_sva #(
    parameter int CNT_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire reg_bits_pkg::access_req_t req,
    input wire reg_bits_pkg::access_rsp_t rsp,
    input wire reg_bits_pkg::hw_in_t hw,
    input wire logic [7:0] ctrl_rw,
    input wire logic [3:0] ctrl_immune,
    input wire logic soft_reset,
    input wire logic [3:0] cmd_pulse,
    input wire logic [3:0] cmd_enable,
    input wire logic key_stb,
    input wire logic [15:0] key_data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Requests in the soft reset cycle are lost
    logic go_w;
    logic go_r;
    logic a_cmd;
    logic a_ctl;
    logic a_key;
    assign go_w = req.wr && !soft_reset;
    assign go_r = req.rd && !soft_reset;
    assign a_cmd = req.addr == reg_bits_pkg::OFS_COMMAND;
    assign a_ctl = req.addr == reg_bits_pkg::OFS_CTRL;
    assign a_key = req.addr == reg_bits_pkg::OFS_KEY;

    chk_status_live: assert property (go_r &&
        req.addr == reg_bits_pkg::OFS_HW_STATUS
        |=> rsp.valid && rsp.data == $past(hw.status))
        else $error("status read not live");
    chk_key_read: assert property (go_r && a_key
        |=> rsp.data == 16'h0000) else $error("key read not zero");
    chk_key_strobe: assert property (go_w && a_key
        |=> key_stb && key_data == $past(req.wdata))
        else $error("key write lost");
    chk_enable_set: assert property (go_w && a_cmd &&
        hw.enable_clear == 4'h0 |=> cmd_enable ==
        ($past(cmd_enable) | $past(req.wdata[7:4])))
        else $error("enable set wrong");
    chk_pulse_set: assert property (go_w && a_cmd
        |=> cmd_pulse == $past(req.wdata[3:0]))
        else $error("command pulse wrong");
    chk_pulse_idle: assert property (!(go_w && a_cmd)
        |=> cmd_pulse == 4'h0) else $error("pulse not cleared");
    chk_soft_pulse: assert property (go_w && a_ctl &&
        req.wdata[15] |=> soft_reset ##1 !soft_reset)
        else $error("soft reset pulse wrong");
    chk_rw_back: assert property (go_w && a_ctl
        |=> ctrl_rw == $past(req.wdata[7:0]))
        else $error("rw field not written");
    chk_immune_keep: assert property (soft_reset |=>
        ctrl_immune == $past(ctrl_immune) && ctrl_rw == 8'h00)
        else $error("soft reset handling wrong");

    cover property (soft_reset);
    cover property (go_r && req.addr == reg_bits_pkg::OFS_LATCH);
    cover property (go_w && req.addr == reg_bits_pkg::OFS_EVENT);
endmodule

// ---- dv/reg_bits_tb.sv ----
`timescale 1ns/1ps

module reg_bits_tb;
    // Short counter so saturation is reached in a few cycles
    localparam int CW = 4;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    reg_bits_pkg::access_req_t req = '0;
    reg_bits_pkg::access_rsp_t rsp;
    reg_bits_pkg::hw_in_t hw = '0;
    logic [7:0] ctrl_rw;
    logic [3:0] ctrl_immune, cmd_pulse, cmd_enable;
    logic soft_reset, key_stb;
    logic [15:0] key_data, st, d;
    logic [15:0] tab[8] = '{16'h0, 16'h0, 16'h0, 16'h0,
                            16'h0, 16'h0, 16'h00F0, 16'h0};
    int n_errors = 0;
    int check_count = 0;
    int m;

    always #20 core_clk = ~core_clk;

    reg_bits #(.CNT_W(CW)) i_reg_bits (.core_clk(core_clk),
        .rst_b(rst_b), .req(req), .rsp(rsp), .hw(hw),
        .ctrl_rw(ctrl_rw), .ctrl_immune(ctrl_immune),
        .soft_reset(soft_reset), .cmd_pulse(cmd_pulse),
        .cmd_enable(cmd_enable), .key_stb(key_stb),
        .key_data(key_data));

    // ********
    // Tasks
    // ********
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic acc(input logic r, input logic [2:0] a,
                       input logic [15:0] dd, input logic [15:0] e);
        @(negedge core_clk);
        req.rd = r;
        req.wr = !r;
        req.addr = a;
        req.wdata = dd;
        @(negedge core_clk);
        req = '0;
        if (r) begin
            cmp(16'(rsp.valid), 16'h0001);
            cmp(rsp.data, e);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] dd);
        acc(1'b0, a, dd, 16'h0000);
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        acc(1'b1, a, 16'h0000, e);
    endtask

    // Reserved positions are masked off before the compare
    task automatic rdm(input logic [2:0] a, input logic [15:0] k,
                       input logic [15:0] e);
        @(negedge core_clk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge core_clk);
        req = '0;
        cmp(16'(rsp.valid), 16'h0001);
        cmp(rsp.data & k, e);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ********
    // Tests
    // ********
    initial begin
        #200000;
        n_errors++;
        results();
    end

    initial begin
        void'($urandom(32'h3769C07A));
        st = 16'($urandom);
        hw.status = st;
        hw.low_cond = 4'hF;
        tab[1] = st;
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), tab[a]);
        end
        wr(3'h1, 16'($urandom));
        wr(3'h6, 16'h0FFF);
        rd(3'h1, st);
        rd(3'h6, 16'h00F0);
        wr(3'h0, 16'h0CA5);
        rd(3'h0, 16'h0CA5);
        wr(3'h3, 16'h0015);
        cmp(16'(cmd_pulse), 16'h0005);
        cmp(16'(cmd_enable), 16'h0001);
        wr(3'h3, 16'h0020);
        wr(3'h3, 16'h0000);
        rd(3'h3, 16'h0030);
        hw.enable_clear = 4'h1;
        @(negedge core_clk);
        hw.enable_clear = 4'h0;
        rd(3'h3, 16'h0020);
        wr(3'h0, 16'h8C5A);
        cmp(16'(soft_reset), 16'h0001);
        rd(3'h0, 16'h0C00);
        cmp(16'(cmd_enable), 16'h0000);
        hw.event_pulse = 4'hF;
        @(negedge core_clk);
        hw.event_pulse = 4'h0;
        m = 15;
        for (int i = 0; i < 3; i++) begin
            d = 16'($urandom) & 16'h000F;
            m = m & ~int'(d);
            wr(3'h2, d);
            rd(3'h2, 16'(m));
        end
        hw.err_pulse = 1'b1;
        repeat (20) @(negedge core_clk);
        hw.err_pulse = 1'b0;
        rd(3'h4, 16'h000F);
        wr(3'h4, 16'($urandom) & 16'h000F);
        rd(3'h4, 16'h0000);
        hw.hit_pulse = 1'b1;
        repeat (3) @(negedge core_clk);
        hw.hit_pulse = 1'b0;
        wr(3'h5, 16'h000F);
        rd(3'h5, 16'h0003);
        rd(3'h5, 16'h0000);
        hw.high_event = 4'h2;
        hw.low_cond = 4'hB;
        hw.sticky_cond = 4'h1;
        @(negedge core_clk);
        hw.high_event = 4'h0;
        hw.low_cond = 4'hF;
        hw.sticky_cond = 4'h2;
        rd(3'h6, 16'h03B2);
        rd(3'h6, 16'h02F0);
        hw.sticky_cond = 4'h0;
        rd(3'h6, 16'h02F0);
        rd(3'h6, 16'h00F0);
        rdm(3'h3, 16'h00FF, 16'h0000);
        d = 16'($urandom);
        wr(3'h7, d);
        cmp(16'(key_stb), 16'h0001);
        cmp(key_data, d);
        results();
    end
endmodule

bind reg_bits reg_bits_sva #(.CNT_W(CNT_W)) i_reg_bits_sva (
    .core_clk(core_clk), .rst_b(rst_b), .req(req), .rsp(rsp),
    .hw(hw), .ctrl_rw(ctrl_rw), .ctrl_immune(ctrl_immune),
    .soft_reset(soft_reset), .cmd_pulse(cmd_pulse),
    .cmd_enable(cmd_enable), .key_stb(key_stb), .key_data(key_data));
